// ===== core/fmc_decade.v
// One BCD decade with count enable, clear and carry out.
// Assumes a single clock domain; enables are one-cycle pulses.
`timescale 1ns/100ps
module fmc_decade (
   // Clock and reset
   input  wire       mclk,
   input  wire       rst_n,
   // Control
   input  wire       clkEn,
   input  wire       clear,
   input  wire       countIn,
   // Digit
   output reg  [3:0] digit,
   output wire       carryOut
);
   assign carryOut = countIn & (digit == 4'h9);
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         digit <= 4'h0;
      end else if (clkEn) begin
         if (clear) begin
            digit <= 4'h0;
         end else if (countIn) begin
            digit <= (digit == 4'h9) ? 4'h0 : digit + 4'h1;
         end
      end
   end
endmodule

// ===== core/fmc_memory_unit.v
// Frequency memory: gated decade counter, store latch, preset divider,
// one-shot, phase comparator, loop filter and recall switch.
// Assumes all inputs synchronous to mclk; oscillators pre-sampled.
//
// Behaviour
// - Only gated tuning pulses reach six-digit counter
// - Crystal-derived 50 Hz pulses drive counter gate
// - BCD digits latched; upper five loaded as divider preset
// - Preset divider ratio 5000 to 55000
// - Shaped memory oscillator pulse clocks divider
// - Divider output stretched, compared to 100 Hz
// - Comparator output lowpass filtered steers oscillator
// - Store switch latches count, holds lock
// - Recall switch routes memory oscillator to synthesizer
// - Gate logic clears counter as each interval opens
// - Crystal generator also gives 200 Hz output
`timescale 1ns/100ps
`include "fmc_defs.vh"
module fmc_memory_unit #(
   parameter GATE_HALF = `FMC_GATE_HALF,
   parameter REF_HALF  = `FMC_REF_HALF,
   parameter AUX_HALF  = `FMC_AUX_HALF,
   parameter FILT_SH   = 4
) (
   // Clock, reset, enable
   input  wire        mclk,
   input  wire        rst_n,
   input  wire        clkEn,
   // Oscillators and crystal tick
   input  wire        xtalTick,
   input  wire        tuneOsc,
   input  wire        memOsc,
   // Switches
   input  wire        storeSwitch,
   input  wire        recall_stored_frequency_switch,
   // Outputs
   output reg  [23:0] storedFreq,
   output reg  [23:0] measuredFreq,
   output reg         gateOut,
   output reg         ref100,
   output reg         aux200,
   output reg         cmpUp,
   output reg         cmpDown,
   output reg  [15:0] steer,
   output reg         synthOsc,
   output reg         stored,
   output reg         divPulse
);
   // ----------------------------------------------------
   // Crystal clock generator
   // ----------------------------------------------------
   reg  [15:0] gateCnt;
   reg  [15:0] refCnt;
   reg  [15:0] auxCnt;
   reg         refPrev;
   wire        refRise = ref100 & ~refPrev;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gateCnt <= 16'h0000;
         refCnt  <= 16'h0000;
         auxCnt  <= 16'h0000;
         gateOut <= 1'b0;
         ref100  <= 1'b0;
         aux200  <= 1'b0;
         refPrev <= 1'b0;
      end else if (clkEn) begin
         refPrev <= ref100;
         if (xtalTick) begin
            if (gateCnt == GATE_HALF - 1) begin
               gateCnt <= 16'h0000;
               gateOut <= ~gateOut;
            end else begin
               gateCnt <= gateCnt + 16'h0001;
            end
            if (refCnt == REF_HALF - 1) begin
               refCnt <= 16'h0000;
               ref100 <= ~ref100;
            end else begin
               refCnt <= refCnt + 16'h0001;
            end
            if (auxCnt == AUX_HALF - 1) begin
               auxCnt <= 16'h0000;
               aux200 <= ~aux200;
            end else begin
               auxCnt <= auxCnt + 16'h0001;
            end
         end
      end
   end
   // ----------------------------------------------------
   // Gate logic and edge detection
   // ----------------------------------------------------
   reg  gatePrev;
   reg  tunePrev;
   reg  memPrev;
   wire gateOpen  = gateOut & ~gatePrev;
   wire gateClose = ~gateOut & gatePrev;
   wire tuneEdge  = tuneOsc & ~tunePrev;
   wire memEdge   = memOsc & ~memPrev;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gatePrev <= 1'b0;
         tunePrev <= 1'b0;
         memPrev  <= 1'b0;
      end else if (clkEn) begin
         gatePrev <= gateOut;
         tunePrev <= tuneOsc;
         memPrev  <= memOsc;
      end
   end
   // ----------------------------------------------------
   // Six-digit gated decade counter
   // ----------------------------------------------------
   wire [`FMC_DIGITS:0]   carry;
   wire [`FMC_DIGITS*4-1:0] count;
   assign carry[0] = tuneEdge & gateOut & ~gateOpen;
   genvar d;
   generate
      for (d = 0; d < `FMC_DIGITS; d = d + 1) begin : gDec
         fmc_decade uDec (
            .mclk     (mclk),
            .rst_n    (rst_n),
            .clkEn    (clkEn),
            .clear    (gateOpen),
            .countIn  (carry[d]),
            .digit    (count[d*4+3:d*4]),
            .carryOut (carry[d+1])
         );
      end
   endgenerate
   // ----------------------------------------------------
   // Store latch
   // ----------------------------------------------------
   reg  storeArm;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         measuredFreq <= 24'h000000;
         storedFreq   <= 24'h000000;
         storeArm     <= 1'b0;
         stored       <= 1'b0;
      end else if (clkEn) begin
         if (gateClose) begin
            measuredFreq <= count;
         end
         if (storeSwitch) begin
            storeArm <= 1'b1;
         end
         // Latch waits for the end of a full interval
         if (gateClose && (storeArm || storeSwitch)) begin
            storedFreq <= count;
            storeArm   <= 1'b0;
            stored     <= 1'b1;
         end
      end
   end
   // ----------------------------------------------------
   // Preset down-counting divider
   // ----------------------------------------------------
   reg  [16:0] divCnt;
   wire [16:0] presetVal;
   // Ratio from stored digits, clamped to the legal span
   wire [19:0] rawRatio = storedFreq[23:20] * 20'd10000
                        + storedFreq[19:16] * 20'd1000
                        + storedFreq[15:12] * 20'd100
                        + storedFreq[11:8]  * 20'd10
                        + {16'h0000, storedFreq[7:4]};
   assign presetVal = (rawRatio < `FMC_DIV_MIN) ? 17'd5000 :
                      (rawRatio > `FMC_DIV_MAX) ? 17'd55000 :
                      rawRatio[16:0];
   reg  [7:0] shotCnt;
   reg        divOut;
   wire [31:0] shotLoad = `FMC_ONESHOT_CYC;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         divCnt   <= 17'd0;
         divOut   <= 1'b0;
         divPulse <= 1'b0;
         shotCnt  <= 8'h00;
      end else if (clkEn) begin
         divOut <= 1'b0;
         if (memEdge) begin
            if (divCnt <= 17'd1) begin
               divCnt <= presetVal;
               divOut <= 1'b1;
            end else begin
               divCnt <= divCnt - 17'd1;
            end
         end
         if (divOut) begin
            shotCnt  <= shotLoad[7:0];
            divPulse <= 1'b1;
         end else if (shotCnt != 8'h00) begin
            shotCnt <= shotCnt - 8'h01;
            if (shotCnt == 8'h01) begin
               divPulse <= 1'b0;
            end
         end
      end
   end
   // ----------------------------------------------------
   // Phase comparator, loop filter and recall switch
   // ----------------------------------------------------
   reg  shotPrev;
   wire shotRise = divPulse & ~shotPrev;
   reg  [15:0] integ;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         shotPrev <= 1'b0;
         cmpUp    <= 1'b0;
         cmpDown  <= 1'b0;
         integ    <= 16'h8000;
         steer    <= 16'h8000;
         synthOsc <= 1'b0;
      end else if (clkEn) begin
         shotPrev <= divPulse;
         // Phase-frequency detector, reset when both set
         if ((cmpUp | refRise) & (cmpDown | shotRise)) begin
            cmpUp   <= 1'b0;
            cmpDown <= 1'b0;
         end else begin
            cmpUp   <= cmpUp | refRise;
            cmpDown <= cmpDown | shotRise;
         end
         if (stored && cmpUp && integ != 16'hffff) begin
            integ <= integ + 16'h0001;
         end else if (stored && cmpDown && integ != 16'h0000) begin
            integ <= integ - 16'h0001;
         end
         steer <= steer + (integ >>> FILT_SH) - (steer >>> FILT_SH);
         synthOsc <= recall_stored_frequency_switch ? memOsc : tuneOsc;
      end
   end
endmodule

// ===== inc/fmc_defs.vh
// Constants for the frequency memory counter and divider.
// Included by the memory unit design file under core/.
`ifndef FMC_DEFS_VH
`define FMC_DEFS_VH
// -------------------------------------------------------
// Clock and timing
// -------------------------------------------------------
`define FMC_MCLK_HZ      200000000
`define FMC_XTAL_HZ      3276800
`define FMC_GATE_HZ      50
`define FMC_REF_HZ       100
`define FMC_AUX_HZ       200
// Crystal ticks per half period of each output
`define FMC_GATE_HALF    (`FMC_XTAL_HZ / (2 * `FMC_GATE_HZ))
`define FMC_REF_HALF     (`FMC_XTAL_HZ / (2 * `FMC_REF_HZ))
`define FMC_AUX_HALF     (`FMC_XTAL_HZ / (2 * `FMC_AUX_HZ))
// -------------------------------------------------------
// Counter geometry
// -------------------------------------------------------
`define FMC_DIGITS       6
`define FMC_DIV_MIN      5000
`define FMC_DIV_MAX      55000
`define FMC_ONESHOT_NS   1000
`define FMC_ONESHOT_CYC  ((`FMC_ONESHOT_NS * 200 + 999) / 1000)
`endif

// ===== verification/fmc_memory_unit_monitor.sv
// Checker for fmc_memory_unit ports.
// Assumes xtalTick marks crystal periods.
`timescale 1ns/100ps
module fmc_monitor #(
   parameter GATE_HALF = 4,
   parameter REF_HALF  = 2
) (
   // Inputs
   input wire        mclk,
   input wire        rst_n,
   input wire        clkEn,
   input wire        xtalTick,
   input wire        tuneOsc,
   input wire        memOsc,
   input wire        recall_stored_frequency_switch,
   // Outputs
   input wire [23:0] storedFreq,
   input wire [23:0] measuredFreq,
   input wire        gateOut,
   input wire        ref100,
   input wire        stored,
   input wire        synthOsc,
   input wire        divPulse
);
   reg  [15:0] gCnt;
   reg  [15:0] rCnt;
   reg  [15:0] pCnt;
   reg         gOld;
   reg         rOld;
   wire        tick = xtalTick & clkEn;
   wire [23:0] m = measuredFreq;
   wire        bcdOk = m[3:0] < 4'ha && m[7:4] < 4'ha && m[11:8] < 4'ha
      && m[15:12] < 4'ha && m[19:16] < 4'ha && m[23:20] < 4'ha;
   // Ticks within a half period; the release edge counts as a change
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gOld <= 1'b1;
         rOld <= 1'b1;
         gCnt <= 16'h0000;
         rCnt <= 16'h0000;
         pCnt <= 16'h0000;
      end else begin
         gOld <= gateOut;
         rOld <= ref100;
         gCnt <= (gateOut != gOld) ? 16'h0000 : gCnt + tick;
         rCnt <= (ref100 != rOld) ? 16'h0000 : rCnt + tick;
         pCnt <= divPulse ? pCnt + clkEn : 16'h0000;
      end
   end
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   a_synth_route: assert property ($past(rst_n) && $past(clkEn) |->
      synthOsc == ($past(recall_stored_frequency_switch)
      ? $past(memOsc) : $past(tuneOsc))) else $error("synth source");
   a_gate_half: assert property (gCnt < GATE_HALF)
      else $error("gate half");
   a_ref_half: assert property (rCnt < REF_HALF)
      else $error("ref half");
   a_pulse_width: assert property ($fell(divPulse) |-> pCnt == 16'h00c8)
      else $error("pulse width");
   a_meas_close: assert property ($changed(measuredFreq) |->
      !$past(gateOut) && $past(gateOut, 2)) else $error("count moved");
   a_store_copy: assert property ($changed(storedFreq) |->
      storedFreq == measuredFreq) else $error("store copy");
   a_stored_hold: assert property (stored |=> stored)
      else $error("stored dropped");
   a_bcd_digits: assert property (bcdOk) else $error("digit");
   c_div: cover property ($rose(divPulse));
   c_store: cover property ($changed(storedFreq));
   c_recall: cover property (recall_stored_frequency_switch && synthOsc);
endmodule
bind fmc_memory_unit fmc_monitor #(.GATE_HALF(GATE_HALF),
   .REF_HALF(REF_HALF)) mon (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
   .xtalTick(xtalTick), .tuneOsc(tuneOsc), .memOsc(memOsc),
   .recall_stored_frequency_switch(recall_stored_frequency_switch),
   .storedFreq(storedFreq), .measuredFreq(measuredFreq),
   .gateOut(gateOut), .ref100(ref100), .stored(stored),
   .synthOsc(synthOsc), .divPulse(divPulse));

// ===== verification/fmc_memory_unit_tb.sv
// Bench for fmc_memory_unit.
// Assumes the checker binds itself to the design.
`timescale 1ns/100ps
module fmc_memory_unit_tb;
   reg         mclk, rst_n, clkEn, xtalTick, storeSwitch, recallSw;
   wire        tuneOsc, memOsc, gateOut, ref100, aux200;
   wire        synthOsc, stored, divPulse, cmpUp, cmpDown;
   wire [23:0] storedFreq, measuredFreq;
   wire [15:0] steer;
   reg  [3:0]  pv, rs;
   reg  [2:0]  snap;
   reg  [15:0] rows [0:1];
   integer     errors, comparisons, cyc, i, n;
   integer     cnt [0:3];
   fmc_osc_model osc (.mclk(mclk), .tuneOsc(tuneOsc), .memOsc(memOsc));
   fmc_memory_unit #(.GATE_HALF(40), .REF_HALF(20), .AUX_HALF(10)) dut (
      .mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .xtalTick(xtalTick),
      .tuneOsc(tuneOsc), .memOsc(memOsc), .storeSwitch(storeSwitch),
      .recall_stored_frequency_switch(recallSw), .storedFreq(storedFreq),
      .measuredFreq(measuredFreq), .gateOut(gateOut), .ref100(ref100),
      .aux200(aux200), .cmpUp(cmpUp), .cmpDown(cmpDown), .steer(steer),
      .synthOsc(synthOsc), .stored(stored), .divPulse(divPulse));
   function inBand(input [23:0] v);
      inBand = v >= 24'h000009 && v <= 24'h000011;
   endfunction
   task check(input [31:0] seen, input [31:0] want);
      begin
         comparisons = comparisons + 1;
         if (seen !== want) begin
            errors = errors + 1;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, want);
         end
      end
   endtask
   task stop_test;
      begin
         if (errors == 0 && comparisons > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 40000) begin
         errors = errors + 1;
         stop_test;
      end
   end
   initial begin
      errors = 0;
      comparisons = 0;
      cyc = 0;
      rows[0] = 16'h0028;
      rows[1] = 16'h0150;
      rst_n = 1'b0;
      clkEn = 1'b1;
      xtalTick = 1'b1;
      storeSwitch = 1'b0;
      recallSw = 1'b0;
      repeat (6) @(negedge mclk);
      rst_n = 1'b1;
      check(steer, 32'h8000);
      // Rows: recall in bit 8, synth rises per 160 cycles below
      for (i = 0; i < 2; i = i + 1) begin
         recallSw = rows[i][8];
         repeat (4) @(negedge mclk);
         pv = {gateOut, ref100, aux200, synthOsc};
         for (n = 0; n < 4; n = n + 1) cnt[n] = 0;
         repeat (160) begin
            @(negedge mclk);
            rs = {gateOut, ref100, aux200, synthOsc};
            for (n = 0; n < 4; n = n + 1) cnt[n] = cnt[n] + (rs[n] & ~pv[n]);
            pv = rs;
         end
         check(cnt[3], 32'h2);
         check(cnt[2], 32'h4);
         check(cnt[1], 32'h8);
         check(cnt[0], rows[i][7:0]);
      end
      recallSw = 1'b0;
      check(inBand(measuredFreq), 32'h1);
      @(posedge gateOut);
      @(negedge mclk);
      storeSwitch = 1'b1;
      @(negedge mclk);
      storeSwitch = 1'b0;
      check(storedFreq, 32'h0);
      @(negedge gateOut);
      repeat (2) @(negedge mclk);
      check(stored, 32'h1);
      check(inBand(storedFreq), 32'h1);
      @(posedge divPulse);
      @(negedge mclk);
      n = cyc;
      @(posedge divPulse);
      @(negedge mclk);
      check(cyc - n, 32'h2710);
      repeat (50) @(negedge mclk);
      check(cmpUp, 32'h1);
      check(cmpDown, 32'h0);
      check(steer > 16'h8000, 32'h1);
      // Clock enable low must freeze the crystal dividers
      snap = {gateOut, ref100, aux200};
      clkEn = 1'b0;
      repeat (40) @(negedge mclk);
      check({gateOut, ref100, aux200}, snap);
      clkEn = 1'b1;
      stop_test;
   end
endmodule

// ===== verification/fmc_osc_model.sv
// Oscillator model: tuning and memory squares.
// Assumes the design samples them on mclk.
`timescale 1ns/100ps
module fmc_osc_model (
   // Clock
   input  wire mclk,
   // Oscillators
   output reg  tuneOsc,
   output reg  memOsc
);
   reg [1:0] ph = 2'h0;
   initial tuneOsc = 1'b0;
   initial memOsc = 1'b0;
   always @(negedge mclk) begin
      ph <= ph + 2'h1;
      tuneOsc <= ph[1];
      memOsc <= ~memOsc;
   end
endmodule
